//--- verilog/spwm_pkg.sv
// ----------------------------------------------------------------------
// Shared constants of the standard PWM generator
// ----------------------------------------------------------------------
package spwm_pkg;

   // Bus widths and timer count
   localparam int ADR_W = 8;
   localparam int DAT_W = 32;
   localparam int N_TMR = 3;

   // Register byte offsets, block-level registers
   localparam logic [7:0] OFS_PWM_CTRL = 8'h00;
   localparam logic [7:0] OFS_DUTY_HIGH = 8'h04;
   localparam logic [7:0] OFS_DUTY_SHADOW = 8'h08;
   localparam logic [7:0] OFS_TIMER_SELECT = 8'h0c;
   localparam logic [7:0] OFS_PIN_DIRECTION = 8'h10;
   localparam logic [7:0] OFS_MATCH_FLAGS = 8'h14;
   localparam logic [7:0] OFS_STATUS = 8'h18;

   // Per-timer register window: base + stride * index
   localparam logic [3:0] TMR_WIN_FIRST = 4'h2;
   localparam logic [3:0] TMR_WIN_LAST = 4'h4;
   localparam logic [3:0] OFS_TIMER_CTRL = 4'h0;
   localparam logic [3:0] OFS_PERIOD = 4'h4;
   localparam logic [3:0] OFS_TIMER_COUNT = 4'h8;

   // Fields of pwm_ctrl
   localparam int MODE_HI = 3;
   localparam int MODE_LO = 2;
   localparam logic [1:0] MODE_PWM = 2'h3;
   localparam int DLOW_HI = 5;
   localparam int DLOW_LO = 4;

   // Fields of timer_ctrl
   localparam int RUN_BIT = 2;
   localparam int PS_HI = 1;
   localparam int PS_LO = 0;
   localparam logic [1:0] PS_DIV1 = 2'h0;
   localparam logic [1:0] PS_DIV4 = 2'h1;

   // Last prescaler count per ratio: four clocks times 1, 4 or 16
   localparam logic [5:0] PRE_LAST_1 = 6'h03;
   localparam logic [5:0] PRE_LAST_4 = 6'h0f;
   localparam logic [5:0] PRE_LAST_16 = 6'h3f;

   // Reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [7:0] RST_PERIOD = 8'hff;
   localparam logic RST_PIN_DIRECTION = 1'b1;
   localparam logic [1:0] RST_TIMER_SELECT = 2'h0;

   // Clock
   localparam int CLK_PERIOD_NS = 8;

endpackage

//--- verilog/spwm_timer.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------------
// One 8-bit period timer with prescaler and two sub-count bits
// ----------------------------------------------------------------------
module spwm_timer
   import spwm_pkg::*;
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic run,
   input wire logic freeze,
   input wire logic [1:0] ps_sel,
   input wire logic [7:0] period,
   input wire logic cnt_we,
   input wire logic [7:0] cnt_wdata,
   output logic [7:0] count,
   output logic [9:0] tb_next,
   output logic adv,
   output logic wrap
);

   typedef struct packed {
      logic [5:0] pre;
      logic [7:0] cnt;
   } spwm_tmr_s;

   spwm_tmr_s s_q;
   spwm_tmr_s s_d;
   logic [5:0] pre_last;

   // Next state of prescaler and count
   always_comb begin
      s_d = s_q;
      wrap = 1'b0;
      adv = 1'b0;
      case (ps_sel)
         PS_DIV1: pre_last = PRE_LAST_1;
         PS_DIV4: pre_last = PRE_LAST_4;
         default: pre_last = PRE_LAST_16;
      endcase
      if (cnt_we) begin
         s_d.cnt = cnt_wdata;
         s_d.pre = '0;
      end else if (run && !freeze) begin
         adv = 1'b1;
         if (s_q.pre == pre_last) begin
            s_d.pre = '0;
            if (s_q.cnt == period) begin
               s_d.cnt = '0;
               wrap = 1'b1;
            end else begin
               s_d.cnt = s_q.cnt + 8'h01;
            end
         end else begin
            s_d.pre = s_q.pre + 6'h01;
         end
      end
      // Low two bits: clock phase at 1:1, prescaler bits otherwise
      case (ps_sel)
         PS_DIV1: tb_next = {s_d.cnt, s_d.pre[1:0]};
         PS_DIV4: tb_next = {s_d.cnt, s_d.pre[3:2]};
         default: tb_next = {s_d.cnt, s_d.pre[5:4]};
      endcase
   end

   // State register
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign count = s_q.cnt;

endmodule // spwm_timer

//--- verilog/spwm_top.sv
`timescale 1ns/100ps
// How it works
// - One output pin carries a PWM waveform of up to 10 bits resolution.
// - Writing zero to pwm_ctrl leaves PWM and releases the pin.
// - Two-bit timer_select picks one of three 8-bit period timers.
// - Period is (period_reg + 1) times four clocks times prescale.
// - After count equals period: count clears, pin rises unless the new duty is zero, duty is latched.
// - Postscaler bits are stored but never shape the period.
// - Duty is duty_high_bits above the two duty_low_bits of pwm_ctrl.
// - Duty writes are taken anytime but apply at the next period end.
// - duty_shadow is read-only while PWM mode is selected.
// - duty_shadow plus a 2-bit latch double-buffer the duty value.
// - Time base is count with two sub-bits from clock or prescaler.
// - Time base equal to buffered duty drives the pin low.
// - High time is duty times clock period times prescale.
// - Duty ratio is duty over four times (period_reg + 1).
// - Resolution grows with period_reg, full 10 bits at 255.
// - A duty beyond the period never matches; the pin keeps its level.
// - Prescale ratios are 1, 4 and 16.
// - Sleep freezes timers and the pin; counting resumes on wake.
// - Reset restores all registers and turns the pin to input.
module spwm_top
   import spwm_pkg::*;
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [DAT_W-1:0] wb_dat_i,
   output logic [DAT_W-1:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic sleep_req,
   output logic pwm_out_pin_o,
   output logic pwm_out_pin_oe
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic ack;
      logic [DAT_W-1:0] dat;
      logic [7:0] pwm_ctrl;
      logic [7:0] duty_high;
      logic [7:0] duty_shadow;
      logic [1:0] duty_latch;
      logic [1:0] timer_select;
      logic pin_direction;
      logic [N_TMR-1:0] match_flag;
      logic [N_TMR-1:0][7:0] timer_ctrl;
      logic [N_TMR-1:0][7:0] period;
      logic level;
      logic out;
      logic oe;
      logic sleep_s1;
      logic sleep_s2;
   } spwm_top_s;

   spwm_top_s s_q;
   spwm_top_s s_d;

   logic [N_TMR-1:0][7:0] t_count;
   logic [N_TMR-1:0][9:0] t_tb_next;
   logic [N_TMR-1:0] t_adv;
   logic [N_TMR-1:0] t_wrap;
   logic [N_TMR-1:0] t_cnt_we;
   logic wr_go;
   logic rd_go;
   logic tmr_win;
   logic [3:0] tmr_idx;
   logic pwm_mode;
   logic sel_valid;
   logic sel_adv;
   logic sel_wrap;
   logic [9:0] sel_tb;
   logic [9:0] duty_new;
   logic [9:0] duty_buf;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------

   // Write commits on the edge where the master sees ack
   assign wr_go = wb_cyc_i && wb_stb_i && wb_we_i && s_q.ack && wb_sel_i[0];
   assign rd_go = wb_cyc_i && wb_stb_i && !s_q.ack;
   assign tmr_win = (wb_adr_i[7:4] >= TMR_WIN_FIRST) && (wb_adr_i[7:4] <= TMR_WIN_LAST);
   assign tmr_idx = wb_adr_i[7:4] - TMR_WIN_FIRST;

   // ----------------------------------------------------------------
   // Period timers
   // ----------------------------------------------------------------
   generate
      for (genvar k = 0; k < N_TMR; k++) begin : g_tmr
         assign t_cnt_we[k] = wr_go && tmr_win && (tmr_idx == 4'(k))
                              && (wb_adr_i[3:0] == OFS_TIMER_COUNT);
         spwm_timer u_tmr (
            .mclk(mclk),
            .nrst(nrst),
            .run(s_q.timer_ctrl[k][RUN_BIT]),
            .freeze(s_q.sleep_s2),
            .ps_sel(s_q.timer_ctrl[k][PS_HI:PS_LO]),
            .period(s_q.period[k]),
            .cnt_we(t_cnt_we[k]),
            .cnt_wdata(wb_dat_i[7:0]),
            .count(t_count[k]),
            .tb_next(t_tb_next[k]),
            .adv(t_adv[k]),
            .wrap(t_wrap[k])
         );
      end
   endgenerate

   // Time base selection; the unused code selects nothing
   assign sel_valid = (s_q.timer_select < 2'(N_TMR));
   assign sel_adv = sel_valid && t_adv[s_q.timer_select];
   assign sel_wrap = sel_valid && t_wrap[s_q.timer_select];
   assign sel_tb = sel_valid ? t_tb_next[s_q.timer_select] : '0;

   // Duty assembly
   assign pwm_mode = (s_q.pwm_ctrl[MODE_HI:MODE_LO] == MODE_PWM);
   assign duty_new = {s_q.duty_high, s_q.pwm_ctrl[DLOW_HI:DLOW_LO]};
   assign duty_buf = {s_q.duty_shadow, s_q.duty_latch};

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      // Sleep level from outside, two flops
      s_d.sleep_s1 = sleep_req;
      s_d.sleep_s2 = s_q.sleep_s1;

      // Bus answer, one cycle after the request
      s_d.ack = rd_go;
      s_d.dat = '0;
      if (rd_go) begin
         if (tmr_win) begin
            case (wb_adr_i[3:0])
               OFS_TIMER_CTRL: s_d.dat[7:0] = s_q.timer_ctrl[tmr_idx[1:0]];
               OFS_PERIOD: s_d.dat[7:0] = s_q.period[tmr_idx[1:0]];
               OFS_TIMER_COUNT: s_d.dat[7:0] = t_count[tmr_idx[1:0]];
               default: s_d.dat = '0;
            endcase
         end else begin
            case (wb_adr_i)
               OFS_PWM_CTRL: s_d.dat[7:0] = s_q.pwm_ctrl;
               OFS_DUTY_HIGH: s_d.dat[7:0] = s_q.duty_high;
               OFS_DUTY_SHADOW: s_d.dat[7:0] = s_q.duty_shadow;
               OFS_TIMER_SELECT: s_d.dat[1:0] = s_q.timer_select;
               OFS_PIN_DIRECTION: s_d.dat[0] = s_q.pin_direction;
               OFS_MATCH_FLAGS: s_d.dat[N_TMR-1:0] = s_q.match_flag;
               OFS_STATUS: s_d.dat[0] = s_q.level;
               default: s_d.dat = '0;
            endcase
         end
      end

      // Register writes; duty registers accept writes at any time, except duty_shadow while PWM mode is selected
      if (wr_go) begin
         if (tmr_win) begin
            case (wb_adr_i[3:0])
               OFS_TIMER_CTRL: s_d.timer_ctrl[tmr_idx[1:0]] = wb_dat_i[7:0];
               OFS_PERIOD: s_d.period[tmr_idx[1:0]] = wb_dat_i[7:0];
               default: s_d.dat = s_d.dat;
            endcase
         end else begin
            case (wb_adr_i)
               OFS_PWM_CTRL: s_d.pwm_ctrl = wb_dat_i[7:0];
               OFS_DUTY_HIGH: s_d.duty_high = wb_dat_i[7:0];
               OFS_DUTY_SHADOW: begin
                  if (!pwm_mode) begin
                     s_d.duty_shadow = wb_dat_i[7:0];
                  end
               end
               OFS_TIMER_SELECT: s_d.timer_select = wb_dat_i[1:0];
               OFS_PIN_DIRECTION: s_d.pin_direction = wb_dat_i[0];
               OFS_MATCH_FLAGS: s_d.match_flag = s_q.match_flag & ~wb_dat_i[N_TMR-1:0];
               default: s_d.dat = s_d.dat;
            endcase
         end
      end

      // Match flags: a set wins over a clear in the same cycle
      s_d.match_flag = s_d.match_flag | t_wrap;

      // Waveform: rise and reload at period end, fall on duty match
      if (!pwm_mode) begin
         s_d.level = 1'b0;
      end else if (sel_wrap) begin
         s_d.duty_shadow = s_q.duty_high;
         s_d.duty_latch = s_q.pwm_ctrl[DLOW_HI:DLOW_LO];
         s_d.level = (duty_new != '0);
      end else if (sel_adv && (sel_tb == duty_buf)) begin
         s_d.level = 1'b0;
      end

      // Pin driver: PWM mode owns the pin only while direction is output
      s_d.out = s_d.level;
      s_d.oe = (s_d.pwm_ctrl != '0) && pwm_mode && !s_d.pin_direction;
      if (s_d.pwm_ctrl == '0) begin
         s_d.oe = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         s_q.ack <= 1'b0;
         s_q.dat <= '0;
         s_q.pwm_ctrl <= RST_BYTE;
         s_q.duty_high <= RST_BYTE;
         s_q.duty_shadow <= RST_BYTE;
         s_q.duty_latch <= '0;
         s_q.timer_select <= RST_TIMER_SELECT;
         s_q.pin_direction <= RST_PIN_DIRECTION;
         s_q.match_flag <= '0;
         s_q.timer_ctrl <= '0;
         s_q.period <= {N_TMR{RST_PERIOD}};
         s_q.level <= 1'b0;
         s_q.out <= 1'b0;
         s_q.oe <= 1'b0;
         s_q.sleep_s1 <= 1'b0;
         s_q.sleep_s2 <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs straight from flops
   assign wb_ack_o = s_q.ack;
   assign wb_dat_o = s_q.dat;
   assign pwm_out_pin_o = s_q.out;
   assign pwm_out_pin_oe = s_q.oe;

endmodule // spwm_top

//--- tb/spwm_checker.sv
`timescale 1ns/100ps
// ----
// Bus and pin checks
// ----
module spwm_checker
   import spwm_pkg::*;
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [DAT_W-1:0] wb_dat_i,
   input wire logic [DAT_W-1:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic sleep_req,
   input wire logic pwm_out_pin_o,
   input wire logic pwm_out_pin_oe
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);
   sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
   sequence s_ans; wb_ack_o ##1 !wb_ack_o; endsequence
   sequence s_wr(a, v);
      wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == a && wb_dat_i[7:0] == v;
   endsequence
   property p_ack; s_req |=> s_ans; endproperty
   a_ack: assert property (p_ack) else $error("ack late or long");
   property p_cause; $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i); endproperty
   a_cause: assert property (p_cause) else $error("ack without request");
   property p_idle; !wb_ack_o |-> wb_dat_o == '0; endproperty
   a_idle: assert property (p_idle) else $error("read data outside ack");
   property p_rst;
      disable iff (1'b0) !nrst |=> !wb_ack_o && !pwm_out_pin_oe && !pwm_out_pin_o;
   endproperty
   a_rst: assert property (p_rst) else $error("outputs active in reset");
   property p_oe;
      $changed(pwm_out_pin_oe) |-> $past(wb_ack_o && wb_we_i) || $past(wb_ack_o && wb_we_i, 2);
   endproperty
   a_oe: assert property (p_oe) else $error("driver enable moved alone");
   property p_rel; s_wr(OFS_PWM_CTRL, 8'h00) |=> ##[0:1] !pwm_out_pin_oe; endproperty
   a_rel: assert property (p_rel) else $error("pin kept after clear");
   property p_dir; s_wr(OFS_PIN_DIRECTION, 8'h01) |=> ##[0:1] !pwm_out_pin_oe; endproperty
   a_dir: assert property (p_dir) else $error("driver on while input");
   property p_sleep; sleep_req [*6] |-> $stable(pwm_out_pin_o); endproperty
   a_sleep: assert property (p_sleep) else $error("pin moved in sleep");
endmodule // spwm_checker
bind spwm_top spwm_checker spwm_checker_i (.mclk, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
   .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .sleep_req, .pwm_out_pin_o,
   .pwm_out_pin_oe);

//--- tb/spwm_load.sv
`timescale 1ns/100ps
// ----
// Load on the pin, measures each period
// ----
module spwm_load (
   input wire logic mclk,
   input wire logic pin,
   input wire logic oe,
   output logic meas,
   output logic [15:0] hi,
   output logic [15:0] per
);
   logic prev = 1'b0;
   logic armed = 1'b0;
   logic [15:0] cnt = '0;
   logic [15:0] hc = '0;
   wire lvl = oe & pin; // Pulled down while undriven
   // Rise to rise counts
   always @(posedge mclk) begin
      prev <= lvl;
      meas <= 1'b0;
      if (lvl && !prev) begin
         per <= cnt;
         hi <= hc;
         meas <= armed;
         armed <= 1'b1;
         cnt <= 16'h1;
         hc <= 16'h1;
      end else begin
         cnt <= cnt + 16'h1;
         hc <= hc + {15'h0, lvl};
      end
   end
endmodule // spwm_load

//--- tb/tb_top.sv
`timescale 1ns/100ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin mismatches++; \
   $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
// ----
// Bench
// ----
module tb_top
   import spwm_pkg::*;
;
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic sleep_req = 1'b0;
   logic [ADR_W-1:0] wb_adr_i = '0;
   logic [3:0] wb_sel_i = 4'hf;
   logic [DAT_W-1:0] wb_dat_i = '0;
   logic [DAT_W-1:0] wb_dat_o, rdat;
   logic wb_ack_o, pwm_out_pin_o, pwm_out_pin_oe, meas;
   logic [15:0] hi, per;
   logic [31:0] q_exp[$], q_msk[$], q_pwm[$], ev, mv;
   int mismatches = 0;
   int compares = 0;
   int cyc_n = 0;
   int unsigned k, pr, du, ps;
   always #(CLK_PERIOD_NS / 2) mclk = ~mclk;
   spwm_top spwm_top_i (.mclk, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
      .wb_dat_i, .wb_dat_o, .wb_ack_o, .sleep_req, .pwm_out_pin_o, .pwm_out_pin_oe);
   spwm_load spwm_load_i (.mclk, .pin(pwm_out_pin_o), .oe(pwm_out_pin_oe), .meas, .hi, .per);
   // Verdict
   task automatic results();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // One bus cycle; a read leaves a masked note
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, m);
      @(posedge mclk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= w ? d : '0;
      if (!w) begin
         q_exp.push_back(d);
         q_msk.push_back(m);
      end
      do @(posedge mclk); while (wb_ack_o !== 1'b1);
      rdat = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      wb(1'b1, a, d, '0);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, e, '1);
   endtask
   task automatic wm(input int n);
      repeat (n) @(negedge mclk iff meas === 1'b1);
      @(posedge mclk);
   endtask
   task automatic drain();
      while (q_pwm.size() > 0) @(negedge mclk);
   endtask
   // Setup in the recommended order
   task automatic cfg(input int unsigned t, s, p, d);
      logic [7:0] b;
      b = 8'(8'h20 + 16 * t);
      wr(OFS_PIN_DIRECTION, 32'h1);
      wr(b + 8'(OFS_PERIOD), 32'(p));
      wr(OFS_PWM_CTRL, 32'({d[1:0], 4'hc}));
      wr(OFS_DUTY_HIGH, 32'(d >> 2));
      wr(OFS_TIMER_SELECT, 32'(t));
      wr(OFS_MATCH_FLAGS, 32'(1 << t));
      wr(b, 32'(4 + s));
      do wb(1'b0, OFS_MATCH_FLAGS, '0, '0); while (rdat[t] !== 1'b1);
      wr(OFS_PIN_DIRECTION, 32'h0);
   endtask
   // Compares each result with the oldest note
   always @(negedge mclk) begin
      if (wb_ack_o === 1'b1 && !wb_we_i && q_exp.size() > 0) begin
         ev = q_exp.pop_front();
         mv = q_msk.pop_front();
         `CHK(wb_dat_o & mv, ev & mv)
      end
      if (meas === 1'b1 && q_pwm.size() > 0) begin
         ev = q_pwm.pop_front();
         `CHK({hi, per}, ev)
      end
   end
   // Hang limit
   always @(posedge mclk) begin
      cyc_n++;
      if (cyc_n == 40000) begin
         mismatches++;
         results();
      end
   end
   // Scenarios
   initial begin
      void'($urandom(32'h9cfd));
      repeat (12) @(posedge mclk);
      nrst <= 1'b1;
      rd(OFS_PIN_DIRECTION, 32'h1);
      rd(8'h24, 32'hff);
      rd(8'hfc, 32'h0);
      for (k = 0; k < 3; k++) begin
         pr = 2 + $urandom % 6;
         du = 1 + $urandom % (4 * pr + 3);
         ps = 1 << (2 * k);
         cfg(k, k, pr, du);
         wm(2);
         q_pwm.push_back({16'(du * ps), 16'((pr + 1) * 4 * ps)});
         drain();
      end
      rd(OFS_DUTY_SHADOW, 32'(du >> 2));
      wr(OFS_DUTY_SHADOW, 32'h5a);
      rd(OFS_DUTY_SHADOW, 32'(du >> 2));
      wm(1);
      q_pwm.push_back({16'(du * 16), 16'((pr + 1) * 64)});
      wr(OFS_DUTY_HIGH, 32'(pr));
      du = 4 * pr + du % 4;
      q_pwm.push_back({16'(du * 16), 16'((pr + 1) * 64)});
      drain();
      wr(OFS_DUTY_HIGH, 32'hff);
      repeat (3 * (pr + 1) * 64) @(posedge mclk);
      `CHK(pwm_out_pin_o, 1'b1)
      rd(OFS_STATUS, 32'h1);
      wr(OFS_DUTY_HIGH, 32'h0);
      wr(OFS_PWM_CTRL, 32'hc);
      repeat (3 * (pr + 1) * 64) @(posedge mclk);
      `CHK(pwm_out_pin_o, 1'b0)
      wr(OFS_DUTY_HIGH, 32'h1);
      wm(2);
      sleep_req <= 1'b1;
      repeat (100) @(posedge mclk);
      sleep_req <= 1'b0;
      wm(1);
      q_pwm.push_back({16'(64), 16'((pr + 1) * 64)});
      drain();
      wr(OFS_PWM_CTRL, 32'h0);
      repeat (3) @(negedge mclk);
      `CHK(pwm_out_pin_oe, 1'b0)
      results();
   end
endmodule // tb_top
